// ### dv/test_tsr_reg_bank.sv
/*
  Bench for the sensor register bank: a link host reads and writes the
  registers while the bench feeds converter results.
  Assumes the host model and the design are compiled first.
*/
`timescale 1ns/1ps

module test_tsr_reg_bank;
  localparam logic [6:0] DADDR = 7'h2A;  // Link address, arbitrary
  localparam logic [7:0] ID = 8'h3C;  // Arbitrary identification value
  // Limit and hysteresis power-on bytes from 0x04 up
  localparam logic [7:0] LIMS [7] = '{8'h20, 8'h00, 8'h05, 8'h00, 8'h49, 8'h80, 8'h05};
  logic core_clk = 1'b0;  // 25 MHz
  logic sys_rst = 1'b1;  // Async reset
  logic scl;  // Link clock from host
  logic sda_host;  // Host pull-down
  logic sda_out;  // Drive value, only checked to stay low
  logic sda_oe;  // Device pull-down
  wire logic sda_w;  // Resolved wire
  tsr_pkg::tsr_conv_s conv = '0;  // Converter strobe
  logic [7:0] op_config;  // Config port
  int n_mismatch = 0;
  int comparisons = 0;

  // Open-drain wire with pull-up
  assign sda_w = sda_host & ~sda_oe;
  // Clock
  always #20 core_clk = ~core_clk;

  tsr_i2c_host host (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_drv(sda_host));
  tsr_reg_bank #(.DEV_ADDR(DADDR), .ID_CODE(ID)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .conv(conv),
    .op_config(op_config));

  // Byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Verdict
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // One-cycle converter result
  task automatic cnv(input logic [15:0] c);
    @(posedge core_clk) conv <= '{valid: 1'b1, code: c};
    @(posedge core_clk) conv <= '{valid: 1'b0, code: c};
  endtask : cnv

  // Configuration write
  task automatic cfg_wr(input logic [7:0] v);
    host.dat[0] = v;
    host.wr(DADDR, 8'h03, 1);
  endtask : cfg_wr

  // Single byte read and compare
  task automatic rd1(input logic [7:0] p, input logic [7:0] exp, input string what);
    host.rd(DADDR, 1'b1, p, 1);
    chk(host.dat[0], exp, what);
  endtask : rd1

  // Burst over 0x00-0x0B with default config, limits and ID expected
  task automatic chk_map(input logic setp, input logic [7:0] thi, input logic [7:0] tlo);
    host.rd(DADDR, setp, 8'h00, 12);
    chk({7'h00, host.ack}, 8'h01, "ack");
    chk({7'h00, sda_out}, 8'h00, "drive level");
    chk(host.dat[0], thi, "temp hi");
    chk(host.dat[1], tlo, "temp lo");
    chk(host.dat[2], 8'h80, "status");
    chk(host.dat[3], 8'h00, "config");
    for (int i = 0; i < 7; i++) begin
      chk(host.dat[4 + i], LIMS[i], "limit");
    end
    chk(host.dat[11], ID, "id");
    chk(op_config, 8'h00, "cfg port");
  endtask : chk_map

  // Power-on map, write-only and unmapped reads
  task automatic t_power_on;
    chk_map(1'b0, 8'h00, 8'h00);
    rd1(8'h2F, 8'h00, "reset loc");
    rd1(8'h0C, 8'h00, "unmapped");
    $display("done power_on");
  endtask : t_power_on

  // Sixteen-bit result, negative
  task automatic t_conv16;
    cfg_wr(8'h80);
    chk(op_config, 8'h80, "cfg port");
    cnv(16'h8123);
    rd1(8'h02, 8'h10, "status low");
    host.rd(DADDR, 1'b1, 8'h00, 3);
    chk(host.dat[0], 8'h81, "hi");
    chk(host.dat[1], 8'h23, "lo");
    chk(host.dat[2], 8'h80, "status");
    $display("done conv16");
  endtask : t_conv16

  // Thirteen-bit result with flags and hysteresis
  task automatic t_conv13;
    cfg_wr(8'h00);
    cnv(16'h4A07);
    host.rd(DADDR, 1'b1, 8'h00, 3);
    chk(host.dat[0], 8'h4A, "hi");
    chk(host.dat[1], 8'h06, "lo flags");
    chk(host.dat[2], 8'hE0, "status");
    rd1(8'h02, 8'h80, "read clear");
    cnv(16'hFF80);
    cnv(16'h0600);
    rd1(8'h02, 8'h10, "in margin");
    cnv(16'hFF80);
    rd1(8'h01, 8'h81, "lo neg");
    cnv(16'h0800);
    rd1(8'h02, 8'h00, "hyst clear");
    $display("done conv13");
  endtask : t_conv13

  // Mode writes and the ready bit
  task automatic t_oneshot;
    for (int i = 1; i < 4; i++) begin
      cnv(16'h1000);
      cfg_wr(8'(i << 5));
      chk(op_config, 8'(i << 5), "cfg port");
      rd1(8'h02, (i == 3) ? 8'h00 : 8'h80, "ready");
    end
    cfg_wr(8'h00);
    $display("done oneshot");
  endtask : t_oneshot

  // Burst writes and read-only places
  task automatic t_writes;
    for (int i = 0; i < 7; i++) begin
      host.dat[i] = 8'(8'h11 * (i + 1));
    end
    host.wr(DADDR, 8'h04, 7);
    host.rd(DADDR, 1'b1, 8'h04, 7);
    for (int i = 0; i < 7; i++) begin
      chk(host.dat[i], 8'(8'h11 * (i + 1)), "limit rw");
    end
    host.dat[0] = 8'hFF;
    host.wr(DADDR, 8'h00, 1);
    host.wr(DADDR, 8'h0B, 1);
    host.wr(DADDR, 8'h0C, 1);
    rd1(8'h00, 8'h10, "ro temp");
    rd1(8'h0B, ID, "ro id");
    rd1(8'h0C, 8'h00, "unmapped");
    cfg_wr(8'h9F);
    chk(op_config, 8'h9F, "cfg port");
    $display("done writes");
  endtask : t_writes

  // Soft reset, then a foreign address
  task automatic t_soft_reset;
    host.dat[0] = 8'h5A;
    host.wr(DADDR, 8'h2F, 1);
    chk_map(1'b1, 8'h10, 8'h00);
    host.dat[0] = 8'h80;
    host.wr(7'h2B, 8'h03, 1);
    chk({7'h00, host.ack}, 8'h00, "foreign ack");
    chk(op_config, 8'h00, "cfg kept");
    $display("done soft_reset");
  endtask : t_soft_reset

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_power_on();
    t_conv16();
    t_conv13();
    t_oneshot();
    t_writes();
    t_soft_reset();
    end_sim();
  end

  // Watchdog, about 80000 cycles
  initial begin
    #3200000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end
endmodule : test_tsr_reg_bank

// ### dv/tsr_i2c_host.sv
/*
  Behavioural two-wire host: drives the link clock and an open-drain data
  pull-down, writes a pointer then data, or reads bytes at the pointer.
  Assumes the bench resolves the data wire with a pull-up and that core_clk
  runs eight times faster than the link clock.
*/
`timescale 1ns/1ps

module tsr_i2c_host (
  // Timing reference
  input wire logic core_clk,
  // Resolved data wire
  input wire logic sda_w,
  // Link clock and data pull-down, 0 pulls low
  output logic scl,
  output logic sda_drv
);
  // Byte buffer shared with the bench
  logic [7:0] dat [16];
  // Address acknowledge of the last transfer
  logic ack;

  // Idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ack = 1'b0;
  end

  // One bit: clock low six cycles, high two; data set after the fall
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    @(posedge core_clk) sda_drv <= b;
    repeat (5) @(posedge core_clk);
    scl <= 1'b1;
    repeat (2) @(posedge core_clk);
    r = sda_w;
  endtask : bit_io

  // Start or repeated start: data falls while the clock is high
  task automatic start;
    scl <= 1'b0;
    repeat (4) @(posedge core_clk);
    sda_drv <= 1'b1;
    repeat (4) @(posedge core_clk);
    scl <= 1'b1;
    repeat (4) @(posedge core_clk);
    sda_drv <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : start

  // Stop: data rises while the clock is high, bus left idle
  task automatic stop;
    scl <= 1'b0;
    repeat (4) @(posedge core_clk);
    sda_drv <= 1'b0;
    repeat (4) @(posedge core_clk);
    scl <= 1'b1;
    repeat (4) @(posedge core_clk);
    sda_drv <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : stop

  // Byte out, top bit first; returns the acknowledge
  task automatic tx(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    a = ~r;
  endtask : tx

  // Byte in; acknowledged unless it is the last
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask : rx

  // Write transfer of n bytes from dat
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n);
    logic k;
    start();
    tx({a, 1'b0}, ack);
    if (ack) begin
      tx(p, k);
      for (int i = 0; i < n; i++) begin
        tx(dat[i], k);
      end
    end
    stop();
  endtask : wr

  // Optional pointer write, then repeated start and n bytes into dat
  task automatic rd(input logic [6:0] a, input logic setp, input logic [7:0] p, input int n);
    logic k;
    if (setp) begin
      start();
      tx({a, 1'b0}, k);
      tx(p, k);
    end
    start();
    tx({a, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      rx(i == n - 1, dat[i]);
    end
    stop();
  endtask : rd
endmodule : tsr_i2c_host

// ### hw/tsr_pin_sync.sv
/*
  Pin synchroniser for the two-wire link: three flops per pin, a level
  change is taken once the second and third flop agree, with one-cycle
  rise and fall pulses.
  Assumes pins idle high and a clock several times the link rate.
*/
`timescale 1ns/1ps

module tsr_pin_sync #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw pins
  input wire logic [N-1:0] pin_in,
  // Filtered level and edge pulses
  output wire logic [N-1:0] lvl,
  output wire logic [N-1:0] rise,
  output wire logic [N-1:0] fall
);

  for (genvar i = 0; i < N; i++) begin : g_pin
    logic [2:0] sr;  // Shift chain, bit 0 first
    logic lvl_q;  // Accepted level
    logic rise_q;  // Rise pulse
    logic fall_q;  // Fall pulse

    // Three-flop chain and agreement filter
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sr <= 3'h7;
        lvl_q <= 1'b1;
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end else begin
        sr <= {sr[1:0], pin_in[i]};
        rise_q <= 1'b0;
        fall_q <= 1'b0;
        // Change only when flops two and three agree
        if (sr[1] == sr[2] && sr[2] != lvl_q) begin
          lvl_q <= sr[2];
          rise_q <= sr[2];
          fall_q <= ~sr[2];
        end
      end
    end

    assign lvl[i] = lvl_q;
    assign rise[i] = rise_q;
    assign fall[i] = fall_q;
  end

endmodule : tsr_pin_sync

// ### hw/tsr_pkg.sv
/*
  Shared constants and types of the temperature sensor register bank:
  register addresses, power-on values, field positions, the conversion
  carrier and the link engine states.
  Assumes nothing; compiled first.
*/
package tsr_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_TEMP_HI = 8'h00;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CFG = 8'h03;
  localparam logic [7:0] ADDR_UPPER_HI = 8'h04;
  localparam logic [7:0] ADDR_UPPER_LO = 8'h05;
  localparam logic [7:0] ADDR_LOWER_HI = 8'h06;
  localparam logic [7:0] ADDR_LOWER_LO = 8'h07;
  localparam logic [7:0] ADDR_CRIT_HI = 8'h08;
  localparam logic [7:0] ADDR_CRIT_LO = 8'h09;
  localparam logic [7:0] ADDR_HYST = 8'h0A;
  localparam logic [7:0] ADDR_ID = 8'h0B;
  localparam logic [7:0] ADDR_SWRST = 8'h2F;

  // Power-on values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic RDY_N_RST = 1'b0;
  localparam logic [7:0] UPPER_HI_RST = 8'h20;
  localparam logic [7:0] UPPER_LO_RST = 8'h00;
  localparam logic [7:0] LOWER_HI_RST = 8'h05;
  localparam logic [7:0] LOWER_LO_RST = 8'h00;
  localparam logic [7:0] CRIT_HI_RST = 8'h49;
  localparam logic [7:0] CRIT_LO_RST = 8'h80;
  localparam logic [7:0] HYST_RST = 8'h05;

  // Limit and hysteresis bytes, lowest address first
  localparam int LIM_COUNT = 7;
  localparam logic [LIM_COUNT-1:0][7:0] LIM_RST = {HYST_RST, CRIT_LO_RST, CRIT_HI_RST,
    LOWER_LO_RST, LOWER_HI_RST, UPPER_LO_RST, UPPER_HI_RST};

  // Field positions and codes
  localparam int CFG_RES_BIT = 7;
  localparam int CFG_MODE_LSB = 5;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_ONESPS = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Conversion result from the converter, one-cycle valid
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } tsr_conv_s;

  // Link engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } tsr_state_e;

endpackage : tsr_pkg

// ### hw/tsr_reg_bank.sv
/*
  Register bank of a digital temperature sensor behind a two-wire serial
  slave: pointer, temperature, status, configuration, limits, hysteresis,
  identification and software reset.
  Assumes the converter delivers results on core_clk and the link clock
  is much slower than core_clk.
*/
`timescale 1ns/1ps

// Functional notes
// [RULE1] Fourteen registers, each eight bits wide
// [RULE2] Read-only values; reset location is write-only
// [RULE3] Pointer powers up at zero
// [RULE4] Temperature, status, config at 0x00-0x03, zero default
// [RULE5] Limits 0x04-0x09, hysteresis, ID, reset address
// [RULE6] Limit and hysteresis power-on defaults
// [RULE7] Pointer byte first, data follows at pointer
// [RULE8] Temperature read auto-increments high to low
// [RULE9] Temperature stored two's complement, bit 15 sign
// [RULE10] Thirteen-bit mode puts alarm flags in bits 0-2
// [RULE11] Flags: below low, above high, above critical
// [RULE12] Sixteen-bit mode fills bits 0-2 with data
// [RULE13] Step is 1/128 or 1/16 degree
// [RULE14] Status flags clear on read or hysteresis return
// [RULE15] One-shot mode write returns ready inactive
// [RULE16] Ready low on new result, high on read
// [RULE17] Status bits 4-6 report low, high, critical
// [RULE18] Config bit 7 selects resolution
// [RULE19] Unmapped addresses read zero, ignore writes
module tsr_reg_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h2A,  // Link address of this device, arbitrary
  parameter logic [7:0] ID_CODE = 8'hA5  // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Two-wire link pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Converter results
  input wire tsr_pkg::tsr_conv_s conv,
  // Configuration to the sequencer
  output logic [7:0] op_config
);

  logic [1:0] pin_lvl;  // Filtered scl, sda
  logic [1:0] pin_rise;  // Rising edges
  logic [1:0] pin_fall;  // Falling edges
  logic scl_rise;  // Clock edge pulses
  logic scl_fall;
  logic start_cond;  // Data falls, clock high
  logic stop_cond;  // Data rises, clock high
  tsr_pkg::tsr_state_e state;  // Link engine state
  logic [3:0] bit_cnt;  // Bits of current byte
  logic [7:0] rx_sh;  // Received byte
  logic [7:0] tx_sh;  // Byte being sent
  logic rw_bit;  // High for a read transfer
  logic acked;  // Host acked last byte
  logic [7:0] ptr;  // Register select pointer
  logic [7:0] temp_hi;  // Temperature high byte
  logic [7:0] temp_lo;  // Temperature low byte
  logic [2:0] flags;  // Critical, high, low status flags
  logic rdy_n;  // Conversion ready, active low
  logic [7:0] lim [tsr_pkg::LIM_COUNT];  // Limit and hysteresis bytes
  logic [7:0] rd_byte;  // Read mux output
  logic rd_strobe;  // Byte fetched for reading
  logic wr_strobe;  // Data byte complete
  logic ptr_load;  // Pointer byte complete
  logic soft_rst;  // Write to reset location
  logic temp_read;  // Temperature byte fetched
  logic stat_read;  // Status byte fetched
  logic mode_wr;  // One-shot or 1 SPS mode write
  logic res16;  // Sixteen-bit resolution
  logic [15:0] meas16;  // Result as stored
  logic signed [16:0] meas;  // Result, widened
  logic signed [16:0] up_lim;
  logic signed [16:0] lo_lim;
  logic signed [16:0] cr_lim;
  logic signed [16:0] hyst;
  logic [2:0] set_v;  // Flag set conditions
  logic [2:0] clr_v;  // Flag clear conditions

  // True when the address selects a limit or hysteresis byte
  function automatic logic is_lim_f(input logic [7:0] addr);
    return addr >= tsr_pkg::ADDR_UPPER_HI && addr <= tsr_pkg::ADDR_HYST;
  endfunction : is_lim_f

  // Pin synchroniser
  tsr_pin_sync #(
    .N(2)
  ) u_sync (
    .clk(core_clk),
    .rst(sys_rst),
    .pin_in({scl_in, sda_in}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Link conditions
  assign scl_rise = pin_rise[1];
  assign scl_fall = pin_fall[1];
  assign start_cond = pin_fall[0] && pin_lvl[1];
  assign stop_cond = pin_rise[0] && pin_lvl[1];

  // [RULE7] Access strobes from pointer
  assign ptr_load = scl_fall && state == tsr_pkg::ST_PTR && bit_cnt == tsr_pkg::BITS_PER_BYTE;
  assign wr_strobe = scl_fall && state == tsr_pkg::ST_WDATA
    && bit_cnt == tsr_pkg::BITS_PER_BYTE;
  assign rd_strobe = scl_fall && ((state == tsr_pkg::ST_ADDR_ACK && rw_bit)
    || (state == tsr_pkg::ST_RDATA_ACK && acked));
  assign soft_rst = wr_strobe && ptr == tsr_pkg::ADDR_SWRST;
  assign temp_read = rd_strobe && (ptr == tsr_pkg::ADDR_TEMP_HI || ptr == tsr_pkg::ADDR_TEMP_LO);
  assign stat_read = rd_strobe && ptr == tsr_pkg::ADDR_STATUS;
  assign mode_wr = wr_strobe && ptr == tsr_pkg::ADDR_CFG
    && (rx_sh[tsr_pkg::CFG_MODE_LSB +: 2] == tsr_pkg::MODE_ONESHOT
    || rx_sh[tsr_pkg::CFG_MODE_LSB +: 2] == tsr_pkg::MODE_ONESPS);

  // Link engine: bytes in, acks, bytes out
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= tsr_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      rw_bit <= 1'b0;
      acked <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      // Start or repeated start
      state <= tsr_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= tsr_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        tsr_pkg::ST_ADDR, tsr_pkg::ST_PTR, tsr_pkg::ST_WDATA: begin
          if (scl_rise) begin
            rx_sh <= {rx_sh[6:0], pin_lvl[0]};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end else if (scl_fall && bit_cnt == tsr_pkg::BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            if (state == tsr_pkg::ST_ADDR) begin
              rw_bit <= rx_sh[0];
              // Ack own address only
              if (rx_sh[7:1] == DEV_ADDR) begin
                sda_oe <= 1'b1;
                state <= tsr_pkg::ST_ADDR_ACK;
              end else begin
                state <= tsr_pkg::ST_IDLE;
              end
            end else begin
              sda_oe <= 1'b1;
              state <= (state == tsr_pkg::ST_PTR) ? tsr_pkg::ST_PTR_ACK
                : tsr_pkg::ST_WDATA_ACK;
            end
          end
        end
        tsr_pkg::ST_ADDR_ACK: begin
          if (scl_fall && !rw_bit) begin
            // [RULE7] Pointer byte comes first
            sda_oe <= 1'b0;
            state <= tsr_pkg::ST_PTR;
          end
        end
        tsr_pkg::ST_PTR_ACK, tsr_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= tsr_pkg::ST_WDATA;
          end
        end
        tsr_pkg::ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end else if (scl_fall) begin
            if (bit_cnt == tsr_pkg::BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              state <= tsr_pkg::ST_RDATA_ACK;
            end else begin
              sda_oe <= ~tx_sh[6];
              tx_sh <= {tx_sh[6:0], 1'b0};
            end
          end
        end
        tsr_pkg::ST_RDATA_ACK: begin
          if (scl_rise) begin
            acked <= ~pin_lvl[0];
          end else if (scl_fall && !acked) begin
            state <= tsr_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= tsr_pkg::ST_IDLE;
        end
      endcase
      // Fetch next read byte, drive its first bit
      if (rd_strobe) begin
        tx_sh <= rd_byte;
        sda_oe <= ~rd_byte[7];
        bit_cnt <= 4'h0;
        state <= tsr_pkg::ST_RDATA;
      end
    end
  end

  // Open-drain pin only ever pulls low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Register select pointer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // [RULE3] Power-up pointer
      ptr <= tsr_pkg::PTR_RST;
    end else if (soft_rst) begin
      ptr <= tsr_pkg::PTR_RST;
    end else if (ptr_load) begin
      ptr <= rx_sh;
    end else if (rd_strobe || wr_strobe) begin
      // [RULE8] Auto-increment per byte
      ptr <= 8'(ptr + 8'h01);
    end
  end

  // Configuration register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_config <= tsr_pkg::CFG_RST;
    end else if (soft_rst) begin
      op_config <= tsr_pkg::CFG_RST;
    end else if (wr_strobe && ptr == tsr_pkg::ADDR_CFG) begin
      op_config <= rx_sh;
    end
  end

  // Limit and hysteresis bytes
  for (genvar i = 0; i < tsr_pkg::LIM_COUNT; i++) begin : g_lim
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        // [RULE6] Limit defaults
        lim[i] <= tsr_pkg::LIM_RST[i];
      end else if (soft_rst) begin
        lim[i] <= tsr_pkg::LIM_RST[i];
      end else if (wr_strobe && ptr == 8'(tsr_pkg::ADDR_UPPER_HI + i)) begin
        // [RULE5] Limits and hysteresis at 0x04-0x0A
        lim[i] <= rx_sh;
      end
    end
  end

  // [RULE18] Resolution select
  assign res16 = op_config[tsr_pkg::CFG_RES_BIT];
  // [RULE13] Both formats in 1/128 degree units
  assign meas16 = res16 ? conv.code : {conv.code[15:3], 3'h0};
  assign meas = {meas16[15], meas16};
  assign up_lim = {lim[0][7], lim[0], lim[1]};
  assign lo_lim = {lim[2][7], lim[2], lim[3]};
  assign cr_lim = {lim[4][7], lim[4], lim[5]};
  // Whole degrees to 1/128 units
  assign hyst = {2'h0, lim[6], 7'h00};

  // [RULE11] Limit crossings
  assign set_v = {meas > cr_lim, meas > up_lim, meas < lo_lim};
  // [RULE14] Return inside limits with hysteresis
  assign clr_v = {meas < cr_lim - hyst, meas < up_lim - hyst, meas > lo_lim + hyst};

  // Temperature value registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_hi <= tsr_pkg::TEMP_RST;
      temp_lo <= tsr_pkg::TEMP_RST;
    end else if (conv.valid) begin
      // [RULE9] Two's complement, bit 15 sign
      temp_hi <= meas16[15:8];
      if (res16) begin
        // [RULE12] Full sixteen-bit data
        temp_lo <= meas16[7:0];
      end else begin
        // [RULE10] Flags in low three bits
        temp_lo <= {meas16[7:3], set_v};
      end
    end
  end

  // Status flags; a new crossing wins over a clear
  for (genvar f = 0; f < 3; f++) begin : g_flag
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        flags[f] <= tsr_pkg::FLAGS_RST[f];
      end else if (conv.valid && set_v[f]) begin
        // [RULE17] Set on crossing
        flags[f] <= 1'b1;
      end else if (soft_rst) begin
        flags[f] <= tsr_pkg::FLAGS_RST[f];
      end else if (stat_read || (conv.valid && clr_v[f])) begin
        // [RULE14] Clear on read or return
        flags[f] <= 1'b0;
      end
    end
  end

  // Conversion ready, active low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_n <= tsr_pkg::RDY_N_RST;
    end else if (conv.valid) begin
      // [RULE16] New result written
      rdy_n <= 1'b0;
    end else if (soft_rst) begin
      rdy_n <= tsr_pkg::RDY_N_RST;
    end else if (temp_read || mode_wr) begin
      // [RULE15] Inactive on temperature read or mode write
      rdy_n <= 1'b1;
    end
  end

  // Read mux over the register map
  always_comb begin
    // [RULE19] Unmapped and write-only read zero
    rd_byte = 8'h00;
    // [RULE1] Eight-bit register decode
    case (ptr)
      // [RULE4] Low four addresses
      tsr_pkg::ADDR_TEMP_HI: rd_byte = temp_hi;
      tsr_pkg::ADDR_TEMP_LO: rd_byte = temp_lo;
      tsr_pkg::ADDR_STATUS: rd_byte = {rdy_n, flags, 4'h0};
      tsr_pkg::ADDR_CFG: rd_byte = op_config;
      // [RULE2] Identification is read-only
      tsr_pkg::ADDR_ID: rd_byte = ID_CODE;
      default: begin
        if (is_lim_f(ptr)) begin
          rd_byte = lim[3'(ptr - tsr_pkg::ADDR_UPPER_HI)];
        end
      end
    endcase
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  ptr_at_reset_a: assert property ($past(sys_rst) |-> ptr == tsr_pkg::PTR_RST)  // [RULE3]
    else $error("pointer not zero after reset");
  temp_ro_a: assert property (wr_strobe && ptr <= tsr_pkg::ADDR_STATUS  // [RULE2]
    && !conv.valid |=> $stable(temp_hi) && $stable(temp_lo) && $stable(rdy_n))
    else $error("read-only register changed by write");
  cfg_write_a: assert property (wr_strobe && ptr == tsr_pkg::ADDR_CFG |=>  // [RULE7]
    op_config == $past(rx_sh))
    else $error("config write lost");
  ptr_incr_a: assert property (rd_strobe && !start_cond |=>  // [RULE8]
    ptr == 8'($past(ptr) + 8'h01))
    else $error("pointer did not increment");
  flag_bits_a: assert property (conv.valid && !res16 |=>  // [RULE10]
    temp_lo[2:0] == $past(set_v) && temp_hi == $past(conv.code[15:8]))
    else $error("flag bits wrong in 13-bit mode");
  full_data_a: assert property (conv.valid && res16 |=>  // [RULE12]
    {temp_hi, temp_lo} == $past(conv.code))
    else $error("16-bit data not stored");
  stat_clear_a: assert property (stat_read && !conv.valid |=> flags == 3'h0)  // [RULE14]
    else $error("status flags not cleared on read");
  conv_rdy_a: assert property (conv.valid |=> !rdy_n)  // [RULE16]
    else $error("ready not set on new result");
  rdy_cycle_a: assert property (temp_read && !conv.valid |=> rdy_n)  // [RULE16]
    else $error("ready not released on temperature read");
  mode_rdy_a: assert property (mode_wr && !conv.valid |=> rdy_n)  // [RULE15]
    else $error("ready not released on mode write");
  crit_set_a: assert property (conv.valid && meas > cr_lim |=> flags[2]  // [RULE17]
    && (res16 || temp_lo[2]))
    else $error("critical crossing not flagged");
  unmapped_rd_a: assert property (rd_strobe && ptr > tsr_pkg::ADDR_ID  // [RULE19]
    |=> tx_sh == 8'h00)
    else $error("unmapped read not zero");
  swrst_def_a: assert property (soft_rst |=> lim[4] == tsr_pkg::CRIT_HI_RST  // [RULE6]
    && lim[5] == tsr_pkg::CRIT_LO_RST && lim[0] == tsr_pkg::UPPER_HI_RST
    && lim[6] == tsr_pkg::HYST_RST)
    else $error("soft reset defaults wrong");

  read_temp_c: cover property (temp_read ##[1:200] temp_read);
  write_cfg_c: cover property (wr_strobe && ptr == tsr_pkg::ADDR_CFG);
  conv16_c: cover property (conv.valid && res16);
  stat_read_c: cover property (stat_read && flags != 3'h0);

endmodule : tsr_reg_bank
